// *** serial_port_pkg.sv ***
// package: register layout, field positions, reset values and types of the serial port block
package serial_port_pkg;
  // line_config field positions
  localparam int CFG_STOP_BIT   = 0;
  localparam int CFG_EVEN_BIT   = 1;
  localparam int CFG_PDIS_BIT   = 2;
  localparam int CFG_LEN_LO_BIT = 3;
  localparam int CFG_LEN_HI_BIT = 4;
  localparam logic [7:0] CFG_RESET = 8'h18;  // 8 data bits, parity on, odd, one stop bit
  // serial_status_port field positions
  localparam int ST_CD_BIT      = 0;
  localparam int ST_OVERRUN_BIT = 1;
  localparam int ST_FRAMING_BIT = 2;
  localparam int ST_PARITY_BIT  = 3;
  localparam int ST_TBE_BIT     = 4;
  localparam int ST_OPTION_BIT  = 5;
  // parallel port bit positions
  localparam int PC_CTS_BIT     = 4;
  localparam int PC_DSR_BIT     = 5;
  localparam int PB_DTR_BIT     = 6;
  localparam int PB_RTS_BIT     = 7;
  localparam int PB_PATH_BIT    = 3;
  localparam int MODEM_EN_BIT   = 1;
  // oversampling of the reference clock
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
  localparam logic [3:0] SAMPLE_MID      = 4'h7;

  typedef enum logic [2:0] {
    TX_IDLE   = 3'b000,
    TX_START  = 3'b001,
    TX_DATA   = 3'b011,
    TX_PARITY = 3'b010,
    TX_STOP   = 3'b110
  } tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE   = 3'b000,
    RX_START  = 3'b001,
    RX_DATA   = 3'b011,
    RX_PARITY = 3'b010,
    RX_STOP   = 3'b110
  } rx_state_t;

  // received word with its error flags
  typedef struct packed {
    logic       framing;
    logic       parity;
    logic [7:0] data;
  } rx_word_t;

  // receive data and modem-control inputs of one path
  typedef struct packed {
    logic rxd;
    logic ctsN;
    logic dsrN;
    logic cd;
  } line_in_t;
endpackage

// *** serial_port_uart_control.sv ***
// serial port control: receiver-transmitter, status and select decodes, path switch
//
// Function
// R1 - processor loads configuration before any traffic
// R2 - processor polls transmit-empty before each write
// R3 - written byte shifts out with start/parity/stop
// R4 - received character raises data-ready output
// R5 - processor checks errors before reading character
// R6 - bit rate comes from programmable timer output
// R7 - config bits: stop, even, disable, length
// R8 - status bits: overrun, framing, parity, empty
// R9 - status bit 5 carries modem option input
// R10 - port select low RS-232C, high modem
// R11 - receive muxed, transmit steered to chosen path
// R12 - CTS/DSR on port C, CD on status
// R13 - DTR and RTS from port B bits
// R14 - received character has its own select
// R15 - modem enable latched from separate port bit
// R16 - sample bit centres, reference divided by sixteen
module serial_port_uart_control (
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  input  wire logic [7:0] busWrData,
  input  wire logic       busWrStrobe,
  input  wire logic       lineConfigSelect,
  input  wire logic       txHoldingSelect,
  input  wire logic       status_port_select,
  input  wire logic       rx_buffer_select,
  input  wire logic       modem_ctrl_port_select,
  input  wire logic       portBWrite,
  input  wire logic       baudRefClk,
  input  wire logic       rs232RxIn,
  input  wire logic       rs232CtsN,
  input  wire logic       rs232DsrN,
  input  wire logic       rs232Cd,
  input  wire logic       modemRxIn,
  input  wire logic       modemCtsN,
  input  wire logic       modemDsrN,
  input  wire logic       modemCd,
  input  wire logic       modem_option_input,
  output logic [7:0]      busRdData,
  output logic [7:0]      portC,
  output logic            rx_data_ready,
  output logic            rs232TxOut,
  output logic            rs232RtsN,
  output logic            rs232DtrN,
  output logic            modemTxOut,
  output logic            modemRtsN,
  output logic            modemDtrN,
  output logic            portSelect,
  output logic            modemEnable
);
  // two-flop synchronisers for every pin input; reset to mark so no false start
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] pinRaw, pinMeta, pinSync;
  assign pinRaw = {baudRefClk, rs232RxIn, rs232CtsN, rs232DsrN, rs232Cd,
                   modemRxIn, modemCtsN, modemDsrN, modemCd, modem_option_input};
  for (genvar g = 0; g < NSYNC; g++) begin : gSync
    always_ff @(posedge sys_clk) begin
      if (!rstn) begin
        pinMeta[g] <= 1'b1;
        pinSync[g] <= 1'b1;
      end else begin
        pinMeta[g] <= pinRaw[g];
        pinSync[g] <= pinMeta[g];
      end
    end
  end
  serial_port_pkg::line_in_t rsIn, mdIn, selIn;
  logic refSync, optionSync;
  assign refSync    = pinSync[9];
  assign rsIn       = pinSync[8:5];
  assign mdIn       = pinSync[4:1];
  assign optionSync = pinSync[0];
  // receive side is picked from the active path only
  assign selIn = portSelect ? mdIn : rsIn; // R11

  // configuration, port B and modem enable latches
  logic [7:0] lineConfig;
  logic [7:0] portB;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      lineConfig  <= serial_port_pkg::CFG_RESET;
      portB       <= 8'hff;
      modemEnable <= 1'b0;
    end else if (busWrStrobe) begin
      if (lineConfigSelect)
        lineConfig <= busWrData; // R1 R7
      if (portBWrite)
        portB <= busWrData;
      if (modem_ctrl_port_select)
        modemEnable <= busWrData[serial_port_pkg::MODEM_EN_BIT]; // R15
    end
  end
  logic stopTwo, evenParity, parityOff;
  logic [1:0] lenCode;
  assign stopTwo    = lineConfig[serial_port_pkg::CFG_STOP_BIT]; // R7
  assign evenParity = lineConfig[serial_port_pkg::CFG_EVEN_BIT];
  assign parityOff  = lineConfig[serial_port_pkg::CFG_PDIS_BIT];
  assign lenCode    = lineConfig[serial_port_pkg::CFG_LEN_HI_BIT:serial_port_pkg::CFG_LEN_LO_BIT];
  logic [2:0] lastBit;
  assign lastBit = 3'h4 + {1'b0, lenCode};  // 5..8 bits
  // reference edge from the timer output, divided by sixteen
  logic refPrev, refTick;
  always_ff @(posedge sys_clk) begin
    if (!rstn)
      refPrev <= 1'b1;
    else
      refPrev <= refSync;
  end
  assign refTick = refSync & ~refPrev; // R6
  // two-entry buffer between the write strobe and the shifter
  logic [7:0] txBuf [2];
  logic [1:0] txCount;
  logic       txWrPtr, txRdPtr, txPush, txPop, txInReady;
  assign txInReady = (txCount != 2'h2);
  assign txPush = busWrStrobe && txHoldingSelect && txInReady; // R2
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      txCount <= 2'h0;
      txWrPtr <= 1'b0;
      txRdPtr <= 1'b0;
    end else begin
      if (txPush) begin
        txBuf[txWrPtr] <= busWrData;
        txWrPtr        <= ~txWrPtr;
      end
      if (txPop)
        txRdPtr <= ~txRdPtr;
      txCount <= txCount + {1'b0, txPush} - {1'b0, txPop};
    end
  end
  // transmitter: one bit every sixteen reference ticks
  serial_port_pkg::tx_state_t txState;
  logic [3:0] txDiv;
  logic [2:0] txBit;
  logic [7:0] txShift;
  logic       txPar, txLine, txSecondStop, txBitEnd;
  assign txBitEnd = refTick && (txDiv == serial_port_pkg::OVERSAMPLE_LAST);
  assign txPop = (txState == serial_port_pkg::TX_IDLE) && (txCount != 2'h0);
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      txState      <= serial_port_pkg::TX_IDLE;
      txDiv        <= 4'h0;
      txBit        <= 3'h0;
      txShift      <= 8'h00;
      txPar        <= 1'b0;
      txLine       <= 1'b1;
      txSecondStop <= 1'b0;
    end else begin
      if (refTick)
        txDiv <= txDiv + 4'h1;
      case (txState)
        serial_port_pkg::TX_IDLE: begin
          txLine <= 1'b1;
          if (txPop) begin
            txShift <= txBuf[txRdPtr];
            txPar   <= ~evenParity;
            txDiv   <= 4'h0;
            txLine  <= 1'b0; // R3
            txState <= serial_port_pkg::TX_START;
          end
        end
        serial_port_pkg::TX_START: begin
          if (txBitEnd) begin
            txLine  <= txShift[0];
            txPar   <= txPar ^ txShift[0];
            txShift <= {1'b0, txShift[7:1]};
            txBit   <= 3'h0;
            txState <= serial_port_pkg::TX_DATA;
          end
        end
        serial_port_pkg::TX_DATA: begin
          if (txBitEnd) begin
            if (txBit == lastBit) begin
              txSecondStop <= stopTwo;
              txLine       <= parityOff ? 1'b1 : txPar;
              txState      <= parityOff ? serial_port_pkg::TX_STOP : serial_port_pkg::TX_PARITY;
            end else begin
              txLine  <= txShift[0];
              txPar   <= txPar ^ txShift[0];
              txShift <= {1'b0, txShift[7:1]};
              txBit   <= txBit + 3'h1;
            end
          end
        end
        serial_port_pkg::TX_PARITY: begin
          if (txBitEnd) begin
            txLine  <= 1'b1; // R3
            txState <= serial_port_pkg::TX_STOP;
          end
        end
        serial_port_pkg::TX_STOP: begin
          if (txBitEnd) begin
            if (txSecondStop)
              txSecondStop <= 1'b0;
            else
              txState <= serial_port_pkg::TX_IDLE;
          end
        end
        default: txState <= serial_port_pkg::TX_IDLE;
      endcase
    end
  end
  // receiver: wait for start, then sample at mid bit
  serial_port_pkg::rx_state_t rxState;
  serial_port_pkg::rx_word_t  rxWord;
  logic [3:0] rxDiv;
  logic [2:0] rxBit;
  logic [7:0] rxShift;
  logic       rxPar, rxMid, rxDone, rxBadParity;
  assign rxMid = refTick && (rxDiv == serial_port_pkg::SAMPLE_MID); // R16
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rxState     <= serial_port_pkg::RX_IDLE;
      rxDiv       <= 4'h0;
      rxBit       <= 3'h0;
      rxShift     <= 8'h00;
      rxPar       <= 1'b0;
      rxDone      <= 1'b0;
      rxBadParity <= 1'b0;
      rxWord      <= '0;
    end else begin
      rxDone <= 1'b0;
      if (refTick)
        rxDiv <= rxDiv + 4'h1;
      case (rxState)
        serial_port_pkg::RX_IDLE: begin
          rxDiv <= 4'h0;
          if (!selIn.rxd)
            rxState <= serial_port_pkg::RX_START;
        end
        serial_port_pkg::RX_START: begin
          if (rxMid) begin
            if (selIn.rxd) begin
              rxState <= serial_port_pkg::RX_IDLE;  // glitch, not a start bit
            end else begin
              rxBit   <= 3'h0;
              rxShift <= 8'h00;
              rxPar   <= ~evenParity;
              rxState <= serial_port_pkg::RX_DATA;
            end
          end
        end
        serial_port_pkg::RX_DATA: begin
          if (rxMid) begin
            rxShift <= {selIn.rxd, rxShift[7:1]};
            rxPar   <= rxPar ^ selIn.rxd;
            rxBit   <= rxBit + 3'h1;
            if (rxBit == lastBit) begin
              rxBadParity <= 1'b0;
              rxState     <= parityOff ? serial_port_pkg::RX_STOP : serial_port_pkg::RX_PARITY;
            end
          end
        end
        serial_port_pkg::RX_PARITY: begin
          if (rxMid) begin
            rxBadParity <= (selIn.rxd != rxPar);
            rxState     <= serial_port_pkg::RX_STOP;
          end
        end
        serial_port_pkg::RX_STOP: begin
          if (rxMid) begin
            // right-justify short characters, upper bits zero
            rxWord.data    <= rxShift >> (3'h7 - lastBit);
            rxWord.parity  <= rxBadParity;
            rxWord.framing <= ~selIn.rxd;
            rxDone         <= 1'b1;
            rxState        <= serial_port_pkg::RX_IDLE;
          end
        end
        default: rxState <= serial_port_pkg::RX_IDLE;
      endcase
    end
  end
  // data ready and overrun; a new character beats a same-cycle read
  logic overrun, rxRead;
  assign rxRead = rx_buffer_select && !busWrStrobe; // R14
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      rx_data_ready <= 1'b0;
      overrun       <= 1'b0;
    end else if (rxDone) begin
      overrun       <= rx_data_ready && !rxRead;
      rx_data_ready <= 1'b1; // R4
    end else if (rxRead) begin
      rx_data_ready <= 1'b0;
    end
  end
  // read mux, registered: one select at a time
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      busRdData <= 8'h00;
    end else if (rxRead) begin
      busRdData <= rxWord.data; // R5 R14
    end else if (status_port_select && !busWrStrobe) begin
      busRdData <= {2'b00,
                    optionSync, // R9
                    (txCount == 2'h0) && (txState == serial_port_pkg::TX_IDLE), // R8
                    rxWord.parity,
                    rxWord.framing,
                    overrun,
                    selIn.cd}; // R12
    end else begin
      busRdData <= 8'h00;
    end
  end
  // port C picture of the selected path's handshake inputs
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      portC <= 8'hff;
    end else begin
      portC <= 8'hff;
      portC[serial_port_pkg::PC_CTS_BIT] <= selIn.ctsN; // R12
      portC[serial_port_pkg::PC_DSR_BIT] <= selIn.dsrN;
    end
  end
  // path select and output steering; idle path held at mark/inactive
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      portSelect <= 1'b0;
      rs232TxOut <= 1'b1;
      rs232RtsN  <= 1'b1;
      rs232DtrN  <= 1'b1;
      modemTxOut <= 1'b1;
      modemRtsN  <= 1'b1;
      modemDtrN  <= 1'b1;
    end else begin
      portSelect <= portB[serial_port_pkg::PB_PATH_BIT]; // R10
      rs232TxOut <= portSelect ? 1'b1 : txLine; // R11
      modemTxOut <= portSelect ? txLine : 1'b1;
      rs232RtsN  <= portSelect ? 1'b1 : portB[serial_port_pkg::PB_RTS_BIT]; // R13
      rs232DtrN  <= portSelect ? 1'b1 : portB[serial_port_pkg::PB_DTR_BIT];
      modemRtsN  <= portSelect ? portB[serial_port_pkg::PB_RTS_BIT] : 1'b1;
      modemDtrN  <= portSelect ? portB[serial_port_pkg::PB_DTR_BIT] : 1'b1;
    end
  end
endmodule

// *** serial_port_uart_control_monitor.sv ***
// checker: port-level properties of the serial port block
module serial_port_uart_control_monitor (
  input wire logic       sys_clk,
  input wire logic       rstn,
  input wire logic [7:0] busWrData,
  input wire logic       busWrStrobe,
  input wire logic       status_port_select,
  input wire logic       rx_buffer_select,
  input wire logic       modem_ctrl_port_select,
  input wire logic       portBWrite,
  input wire logic [7:0] busRdData,
  input wire logic       rx_data_ready,
  input wire logic       rs232TxOut,
  input wire logic       rs232RtsN,
  input wire logic       rs232DtrN,
  input wire logic       modemTxOut,
  input wire logic       modemRtsN,
  input wire logic       modemDtrN,
  input wire logic       portSelect,
  input wire logic       modemEnable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  // read cycles are decodes with the strobe low
  wire rdStat = status_port_select && !busWrStrobe;
  wire rdBuf  = rx_buffer_select && !busWrStrobe;
  wire wrMctl = modem_ctrl_port_select && busWrStrobe;

  property p_rd_idle; !(rdStat || rdBuf) |=> busRdData == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data not idle");
  property p_stat_hi; rdStat |=> busRdData[7:6] == 2'b00; endproperty
  a_stat_hi: assert property (p_stat_hi)
    else $error("status upper bits set");
  // a low line level means the shifter is still mid-frame
  property p_tbe_busy; rdStat && !portSelect && !rs232TxOut |=> !busRdData[4]; endproperty
  a_tbe_busy: assert property (p_tbe_busy)
    else $error("empty flag during frame");
  property p_rdy_hold; rx_data_ready && !rdBuf |=> rx_data_ready; endproperty
  a_rdy_hold: assert property (p_rdy_hold)
    else $error("ready dropped without read");
  // port B latch takes one edge, the path select flop a second one
  property p_sel;
    portBWrite && busWrStrobe |-> ##2 portSelect == $past(busWrData[3], 2);
  endproperty
  a_sel: assert property (p_sel)
    else $error("path select wrong");
  property p_men; wrMctl |=> modemEnable == $past(busWrData[1]); endproperty
  a_men: assert property (p_men)
    else $error("modem enable wrong");
  property p_men_hold; !wrMctl |=> $stable(modemEnable); endproperty
  a_men_hold: assert property (p_men_hold)
    else $error("modem enable moved");
  property p_rs_off;
    portSelect && $past(portSelect) |-> rs232TxOut && rs232RtsN && rs232DtrN;
  endproperty
  a_rs_off: assert property (p_rs_off)
    else $error("rs232 driven while unselected");
  property p_md_off;
    !portSelect && !$past(portSelect) |-> modemTxOut && modemRtsN && modemDtrN;
  endproperty
  a_md_off: assert property (p_md_off)
    else $error("modem driven while unselected");
endmodule

bind serial_port_uart_control serial_port_uart_control_monitor mon (
  .sys_clk(sys_clk), .rstn(rstn), .busWrData(busWrData), .busWrStrobe(busWrStrobe),
  .status_port_select(status_port_select), .rx_buffer_select(rx_buffer_select),
  .modem_ctrl_port_select(modem_ctrl_port_select), .portBWrite(portBWrite),
  .busRdData(busRdData), .rx_data_ready(rx_data_ready), .rs232TxOut(rs232TxOut),
  .rs232RtsN(rs232RtsN), .rs232DtrN(rs232DtrN), .modemTxOut(modemTxOut),
  .modemRtsN(modemRtsN), .modemDtrN(modemDtrN), .portSelect(portSelect),
  .modemEnable(modemEnable)
);

// *** serial_line_model.sv ***
// line model: sends frames to the receive pin, captures transmitted frames
module serial_line_model (
  input wire logic baudRefClk,
  input wire logic txLine,
  output logic     rxLine
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle line rests at mark level
  initial rxLine = 1'b1;
  // stop cut to 12 ticks so a low stop cannot pass for a new start
  task automatic send(input logic [10:0] bits);
    for (int i = 0; i < 11; i++) begin
      rxLine = bits[i];
      repeat (i == 10 ? 12 : 16) @(posedge baudRefClk);
    end
    rxLine = 1'b1;
    // one mark tick, so back-to-back frames never rewrite the line in one step
    @(posedge baudRefClk);
  endtask
  // sample each bit at its centre, half a bit after the start edge
  task automatic capture(input int n, output logic [10:0] bits);
    bits = '0;
    @(negedge txLine);
    repeat (8) @(posedge baudRefClk);
    for (int i = 0; i < n; i++) begin
      bits[i] = txLine;
      repeat (16) @(posedge baudRefClk);
    end
  endtask
endmodule

// *** serial_port_uart_control_test.sv ***
// testbench: scenarios for the serial port block against a line model
module serial_port_uart_control_test;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int CFG = 0, TXB = 1, STAT = 2, RXB = 3, MCTL = 4, PORTB = 5;
  logic        sys_clk, rstn, busWrStrobe, baudRefClk, rx_data_ready;
  logic [7:0]  busWrData, busRdData, portC, q;
  logic [5:0]  sel;
  logic        rsRx, rsCtsN, rsDsrN, rsCd, mdRx, mdCtsN, mdDsrN, mdCd, opt;
  logic        rsTx, rsRtsN, rsDtrN, mdTx, mdRtsN, mdDtrN, portSelect, modemEnable;
  logic [10:0] got;
  int          err_total, checks, cycles;

  serial_port_uart_control dut (
    .sys_clk(sys_clk), .rstn(rstn), .busWrData(busWrData), .busWrStrobe(busWrStrobe),
    .lineConfigSelect(sel[CFG]), .txHoldingSelect(sel[TXB]), .status_port_select(sel[STAT]),
    .rx_buffer_select(sel[RXB]), .modem_ctrl_port_select(sel[MCTL]), .portBWrite(sel[PORTB]),
    .baudRefClk(baudRefClk), .rs232RxIn(rsRx), .rs232CtsN(rsCtsN), .rs232DsrN(rsDsrN),
    .rs232Cd(rsCd), .modemRxIn(mdRx), .modemCtsN(mdCtsN), .modemDsrN(mdDsrN), .modemCd(mdCd),
    .modem_option_input(opt), .busRdData(busRdData), .portC(portC),
    .rx_data_ready(rx_data_ready), .rs232TxOut(rsTx), .rs232RtsN(rsRtsN),
    .rs232DtrN(rsDtrN), .modemTxOut(mdTx), .modemRtsN(mdRtsN), .modemDtrN(mdDtrN),
    .portSelect(portSelect), .modemEnable(modemEnable)
  );
  serial_line_model rs (.baudRefClk(baudRefClk), .txLine(rsTx), .rxLine(rsRx));
  serial_line_model md (.baudRefClk(baudRefClk), .txLine(mdTx), .rxLine(mdRx));

  // system clock 5 ns
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  // timer output: one reference tick per 8 system cycles
  initial begin
    baudRefClk = 1'b0;
    forever #20 baudRefClk = ~baudRefClk;
  end
  // cycle ceiling cuts a hang short
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // one bus cycle; read data lands on the taking edge
  task automatic access(input int s, input logic w, input logic [7:0] d);
    @(posedge sys_clk);
    #1;
    sel = 6'h01 << s;
    busWrStrobe = w;
    busWrData = d;
    @(posedge sys_clk);
    #1;
    sel = '0;
    busWrStrobe = 1'b0;
    q = busRdData;
  endtask

  // poll the empty flag after each transmitted frame
  task automatic wait_tbe();
    for (int i = 0; i < 1000; i++) begin
      access(STAT, 1'b0, 8'h00);
      if (q[4] === 1'b1) break;
    end
    check("tx empty", q[4], 1);
  endtask

  task automatic t_tx(input logic path, input logic [7:0] cfg,
                      input logic [7:0] d, input int n, input logic [10:0] exp);
    access(CFG, 1'b1, cfg);
    fork
      if (path) md.capture(n, got);
      else rs.capture(n, got);
      begin
        access(TXB, 1'b1, d);
        // second read lands while the start bit is already on the line
        repeat (2) access(STAT, 1'b0, 8'h00);
        check("tx busy", q[4], 0);
      end
    join
    check("tx frame", got, exp);
    wait_tbe();
  endtask

  task automatic t_rx(input logic path, input logic [10:0] fr, input logic twice,
                      input logic [2:0] err, input logic [7:0] d);
    repeat (twice ? 2 : 1)
      if (path) md.send(fr);
      else rs.send(fr);
    for (int i = 0; i < 3000 && rx_data_ready !== 1'b1; i++) @(posedge sys_clk);
    #1;
    check("ready", rx_data_ready, 1);
    access(STAT, 1'b0, 8'h00);
    check("error flags", q[3:1], err);
    access(RXB, 1'b0, 8'h00);
    check("rx data", q, d);
    check("ready cleared", rx_data_ready, 0);
  endtask

  initial begin
    {rstn, busWrStrobe, busWrData, sel} = '0;
    {mdCtsN, mdDsrN, mdCd, opt} = 4'b0111;
    {rsCtsN, rsDsrN, rsCd} = 3'b100;
    repeat (10) @(posedge sys_clk);
    #1;
    rstn = 1'b1;
    // pins need two synchroniser edges plus the port C flop
    repeat (4) @(posedge sys_clk);
    #1;
    check("path after reset", portSelect, 1);
    check("modem enable", modemEnable, 0);
    check("port c modem", portC, 8'hef);
    access(STAT, 1'b0, 8'h00);
    check("status modem", q, 8'h31);
    access(MCTL, 1'b1, 8'h02);
    check("modem on", modemEnable, 1);
    access(MCTL, 1'b1, 8'hfd);
    check("modem off", modemEnable, 0);
    opt = 1'b0;
    access(PORTB, 1'b1, 8'h00);
    access(STAT, 1'b0, 8'h00);
    access(STAT, 1'b0, 8'h00);
    check("status rs232", q, 8'h10);
    check("port c rs232", portC, 8'hdf);
    check("rts dtr", {rsRtsN, rsDtrN, mdRtsN}, 3'b001);
    t_tx(1'b0, 8'h18, 8'ha5, 11, {1'b1, 1'b1, 8'ha5, 1'b0});
    t_tx(1'b0, 8'h03, 8'h15, 9, {2'b11, 1'b1, 5'h15, 1'b0});
    t_tx(1'b0, 8'h14, 8'hff, 9, {1'b1, 7'h7f, 1'b0});
    access(CFG, 1'b1, 8'h18);
    t_rx(1'b0, {1'b1, 1'b1, 8'h3c, 1'b0}, 1'b0, 3'b000, 8'h3c);
    t_rx(1'b0, {1'b1, 1'b0, 8'h3c, 1'b0}, 1'b0, 3'b100, 8'h3c);
    t_rx(1'b0, {1'b0, 1'b1, 8'h5a, 1'b0}, 1'b0, 3'b010, 8'h5a);
    t_rx(1'b0, {1'b1, 1'b1, 8'h81, 1'b0}, 1'b1, 3'b001, 8'h81);
    access(PORTB, 1'b1, 8'h08);
    t_rx(1'b1, {1'b1, 1'b1, 8'he7, 1'b0}, 1'b0, 3'b000, 8'he7);
    t_tx(1'b1, 8'h18, 8'h3c, 11, {1'b1, 1'b1, 8'h3c, 1'b0});
    check("modem rts dtr", {mdRtsN, mdDtrN, rsRtsN, rsDtrN, rsTx}, 5'b00111);
    give_verdict();
  end
endmodule
